// [hw/data_pin_driver.sv]
// registered byte steering and enable for the parallel data pins
`timescale 1ns/10ps
module data_pin_driver (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // latched word and controls
   input  wire logic [15:0] latch_word,
   input  wire logic        oe_n,
   input  wire logic        byte_sel,
   // pins, bit 15 is data_pin_first, bit 0 is data_pin_last
   output logic      [15:0] pins_out_q,
   output logic             pins_oe_q
);
   logic [15:0] pins_out_d;
   logic        pins_oe_d;

   always_comb begin
      // (RULE13) low byte always on upper pins
      pins_out_d[7:0]  = latch_word[7:0];
      // (RULE13) byte select steers lower pins
      pins_out_d[15:8] = byte_sel ? latch_word[15:8] : latch_word[7:0];
      // (RULE12) enable low drives pins
      pins_oe_d        = ~oe_n;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_out_q <= 16'h0000;
         pins_oe_q  <= 1'b0;
      end else begin
         pins_out_q <= pins_out_d;
         pins_oe_q  <= pins_oe_d;
      end
   end
endmodule

// [hw/pulse_timer.sv]
// retriggerable pulse of a fixed length with an end-of-pulse strobe
`timescale 1ns/10ps
module pulse_timer #(
   parameter int CYCLES = 8
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // control
   input  wire logic start,
   // status
   output logic      active_q,
   output logic      done_q
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(CYCLES);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          active_d;
   logic          done_d;

   always_comb begin
      cnt_d    = cnt_q;
      active_d = active_q;
      done_d   = 1'b0;
      // a new start restarts the full length
      if (start) begin
         cnt_d    = LOAD;
         active_d = 1'b1;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
         if (cnt_q == CW'(1)) begin
            active_d = 1'b0;
            done_d   = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q    <= '0;
         active_q <= 1'b0;
         done_q   <= 1'b0;
      end else begin
         cnt_q    <= cnt_d;
         active_q <= active_d;
         done_q   <= done_d;
      end
   end
endmodule

// [hw/tracker_defs.svh]
// register offsets, field positions, reset values and timing for the position tracker
`ifndef TRACKER_DEFS_SVH
`define TRACKER_DEFS_SVH

`define TRK_ADDR_W          8
`define TRK_OFF_CTRL        8'h00
`define TRK_OFF_STATUS      8'h04
`define TRK_OFF_POSITION    8'h08
`define TRK_OFF_INT_STAT    8'h0c
`define TRK_OFF_INT_MASK    8'h10
`define TRK_OFF_COUNT       8'h14

`define TRK_CTRL_SEL_A      0
`define TRK_CTRL_SEL_B      1
`define TRK_CTRL_HOLD       2
`define TRK_CTRL_OE_N       3
`define TRK_CTRL_BYTE_SEL   4
`define TRK_CTRL_W          5
`define TRK_CTRL_RESET      5'h08

`define TRK_ST_BUSY         0
`define TRK_ST_CARRY        1
`define TRK_ST_DIR          2
`define TRK_ST_LATCH_VALID  3
`define TRK_ST_RES_LO       4

`define TRK_INT_STEP        0
`define TRK_INT_CARRY       1
`define TRK_INT_DIR         2
`define TRK_INT_VALID       3
`define TRK_INT_W           4

`define TRK_POS_W           16
`define TRK_CLK_NS          20
`define TRK_BUSY_MIN_NS     150
`define TRK_CARRY_MIN_NS    300
`define TRK_VALID_MAX_NS    490
`define TRK_BUSY_CYC        ((`TRK_BUSY_MIN_NS + `TRK_CLK_NS - 1) / `TRK_CLK_NS)
`define TRK_CARRY_CYC       ((`TRK_CARRY_MIN_NS + `TRK_CLK_NS - 1) / `TRK_CLK_NS)
`define TRK_VALID_CYC       (`TRK_VALID_MAX_NS / `TRK_CLK_NS)
`define TRK_RES_MAP         8'he4
`define TRK_DIR_STABLE      2'h2

`endif

// [hw/tracker_pkg.sv]
// types shared by the position tracker files
package tracker_pkg;
   typedef enum logic [1:0] {RES_10, RES_12, RES_14, RES_16} res_e;
   typedef logic [15:0] pos_t;
endpackage

// [hw/tracking_position_counter_outputs.sv]
// tracking position counter with busy, carry, direction, output latch and apb registers
// Overview of operation
// (RULE1) two select inputs choose 10, 12, 14 or 16 bit output width
// (RULE2) count follows the input by one lsb steps, no convert command
// (RULE3) every single lsb count step emits one busy pulse; a step while busy is high restarts that pulse instead
// (RULE4) position is an unsigned natural binary word at the selected width
// (RULE5) carry pulse starts when count wraps all ones to zeros or back
// (RULE6) direction output settles before any carry pulse begins
// (RULE7) direction is latched and flips only on a step the other way
// (RULE8) carry and direction keep working while the hold input is set
// (RULE9) reader should change resolution during motion only while busy is low
// (RULE10) hold blocks only counter to latch transfer; release sends refresh busy
// (RULE11) latched data valid 490 ns after hold, reader then releases hold
// (RULE12) data pins float while enable is high, drive latch when low
// (RULE13) upper pins carry low byte; lower pins high byte when byte select high
// (RULE14) select level to resolution mapping is a parameter
`timescale 1ns/10ps
`include "tracker_defs.svh"
module tracking_position_counter_outputs #(
   parameter logic [7:0] RES_MAP = `TRK_RES_MAP
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // one lsb step requests from the tracking loop
   input  wire logic        step_up,
   input  wire logic        step_down,
   // status pins
   output logic             busy,
   output logic             revolution_carry_pulse,
   output logic             direction,
   output logic             irq,
   // parallel data pins
   output logic      [15:0] data_pins_out,
   output logic             data_pins_oe
);
   // (RULE14) resolution index from the mapping parameter
   function automatic tracker_pkg::res_e res_of(input logic [1:0] sel);
      res_of = tracker_pkg::res_e'(RES_MAP[{sel, 1'b0} +: 2]);
   endfunction

   // (RULE1) width mask per resolution
   function automatic tracker_pkg::pos_t mask_of(input tracker_pkg::res_e r);
      case (r)
         tracker_pkg::RES_10: mask_of = 16'h03ff;
         tracker_pkg::RES_12: mask_of = 16'h0fff;
         tracker_pkg::RES_14: mask_of = 16'h3fff;
         default:             mask_of = 16'hffff;
      endcase
   endfunction

   // registers
   logic [`TRK_CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [`TRK_INT_W-1:0]  int_stat_q, int_stat_d;
   logic [`TRK_INT_W-1:0]  int_mask_q, int_mask_d;
   logic [31:0]            prdata_d;
   logic                   pready_d, pslverr_d, irq_d;
   // tracking state
   tracker_pkg::pos_t      count_q, count_d;
   tracker_pkg::pos_t      latch_q, latch_d;
   logic                   dir_q, dir_d;
   logic                   step_q, step_d;
   logic                   wrap_q, wrap_d;
   logic                   carry_q, carry_d;
   logic                   prev_dir_q, prev_dir_d;
   logic [1:0]             stable_q, stable_d;
   logic                   hold_q, hold_d;
   logic                   valid_q, valid_d;

   // decoded controls
   tracker_pkg::res_e      res;
   tracker_pkg::pos_t      mask;
   logic                   hold, step_req, going_up, wr_en, rd_setup;
   logic                   busy_start, busy_done, carry_held, valid_done;

   assign res      = res_of({ctrl_q[`TRK_CTRL_SEL_B], ctrl_q[`TRK_CTRL_SEL_A]});
   assign mask     = mask_of(res);
   assign hold     = ctrl_q[`TRK_CTRL_HOLD];
   assign step_req = step_up ^ step_down;
   assign going_up = step_up;
   assign wr_en    = psel & penable & pwrite & pready;
   assign rd_setup = psel & ~penable;

   // busy pulse: count steps and hold release both start one
   pulse_timer #(.CYCLES(`TRK_BUSY_CYC)) u_busy (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (busy_start),
      .active_q (busy),
      .done_q   (busy_done)
   );

   // minimum carry width
   pulse_timer #(.CYCLES(`TRK_CARRY_CYC)) u_carry (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (wrap_q),
      .active_q (carry_held),
      .done_q   ()
   );

   // time from hold assertion to guaranteed valid latch
   pulse_timer #(.CYCLES(`TRK_VALID_CYC)) u_valid (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (hold & ~hold_q),
      .active_q (),
      .done_q   (valid_done)
   );

   // (RULE3) each step starts or restarts busy, (RULE10) plus one on hold release
   assign busy_start = step_q | (hold_q & ~hold);

   always_comb begin
      count_d    = count_q & mask;
      dir_d      = dir_q;
      step_d     = 1'b0;
      wrap_d     = 1'b0;
      // (RULE2) each lsb step of the input moves the count, no command
      if (step_req) begin
         step_d = 1'b1;
         // (RULE7) direction only flips on an actual opposite step
         dir_d  = going_up;
         if (going_up) begin
            // (RULE4) natural binary, wraps at selected width
            count_d = (count_q + 16'h0001) & mask;
            // (RULE5) wrap all ones to all zeros
            wrap_d  = (count_q & mask) == mask;
         end else begin
            count_d = (count_q - 16'h0001) & mask;
            // (RULE5) wrap all zeros to all ones
            wrap_d  = (count_q & mask) == 16'h0000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= 16'h0000;
         dir_q   <= 1'b1;
         step_q  <= 1'b0;
         wrap_q  <= 1'b0;
      end else begin
         count_q <= count_d;
         dir_q   <= dir_d;
         step_q  <= step_d;
         wrap_q  <= wrap_d;
      end
   end

   // carry follows direction by one cycle and clears at the first step after its minimum width that agrees in direction with the two steps before it
   always_comb begin
      carry_d    = carry_q;
      prev_dir_d = prev_dir_q;
      stable_d   = stable_q;
      if (step_q) begin
         prev_dir_d = dir_q;
         if (dir_q != prev_dir_q) begin
            stable_d = 2'h0;
         end else if (stable_q != `TRK_DIR_STABLE) begin
            stable_d = stable_q + 2'h1;
         end
         // a direction reversal keeps the carry high until steps agree twice
         if (!carry_held && dir_q == prev_dir_q && stable_q != 2'h0) begin
            carry_d = 1'b0;
         end
      end
      // (RULE6) carry set one cycle after direction has settled
      // (RULE8) carry ignores hold
      if (wrap_q) begin
         carry_d = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carry_q    <= 1'b0;
         prev_dir_q <= 1'b1;
         stable_q   <= 2'h0;
      end else begin
         carry_q    <= carry_d;
         prev_dir_q <= prev_dir_d;
         stable_q   <= stable_d;
      end
   end

   // output latch
   always_comb begin
      latch_d = latch_q;
      hold_d  = hold;
      valid_d = valid_q;
      // (RULE10) hold blocks only the counter to latch transfer
      if (busy_done && !hold) begin
         latch_d = count_q & mask;
      end
      // (RULE11) valid flag after the hold settle time
      if (!hold) begin
         valid_d = 1'b0;
      end else if (valid_done) begin
         valid_d = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_q <= 16'h0000;
         hold_q  <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         latch_q <= latch_d;
         hold_q  <= hold_d;
         valid_q <= valid_d;
      end
   end

   // pins are registered again so they change a cycle after the latch
   data_pin_driver u_pins (
      .pclk       (pclk),
      .presetn    (presetn),
      .latch_word (latch_q),
      .oe_n       (ctrl_q[`TRK_CTRL_OE_N]),
      .byte_sel   (ctrl_q[`TRK_CTRL_BYTE_SEL]),
      .pins_out_q (data_pins_out),
      .pins_oe_q  (data_pins_oe)
   );

   // apb registers, interrupt status and mask
   always_comb begin
      logic [`TRK_INT_W-1:0] ev;
      logic [`TRK_INT_W-1:0] clr;
      ev                  = '0;
      clr                 = '0;
      ev[`TRK_INT_STEP]   = step_q;
      ev[`TRK_INT_CARRY]  = wrap_q;
      ev[`TRK_INT_DIR]    = step_q & (dir_q != prev_dir_q);
      ev[`TRK_INT_VALID]  = valid_done & hold;
      ctrl_d              = ctrl_q;
      int_mask_d          = int_mask_q;
      prdata_d            = 32'h0000_0000;
      pslverr_d           = 1'b0;
      pready_d            = rd_setup;
      if (wr_en) begin
         if (paddr == `TRK_OFF_CTRL) begin
            ctrl_d = pwdata[`TRK_CTRL_W-1:0];
         end else if (paddr == `TRK_OFF_INT_STAT) begin
            clr = pwdata[`TRK_INT_W-1:0];
         end else if (paddr == `TRK_OFF_INT_MASK) begin
            int_mask_d = pwdata[`TRK_INT_W-1:0];
         end
      end
      // set wins over a simultaneous write-one clear
      int_stat_d = (int_stat_q & ~clr) | ev;
      if (rd_setup) begin
         if (paddr == `TRK_OFF_CTRL) begin
            prdata_d[`TRK_CTRL_W-1:0] = ctrl_q;
         end else if (paddr == `TRK_OFF_STATUS) begin
            prdata_d[`TRK_ST_BUSY]        = busy;
            prdata_d[`TRK_ST_CARRY]       = carry_q;
            prdata_d[`TRK_ST_DIR]         = dir_q;
            prdata_d[`TRK_ST_LATCH_VALID] = valid_q;
            prdata_d[`TRK_ST_RES_LO +: 2] = res;
         end else if (paddr == `TRK_OFF_POSITION) begin
            prdata_d[15:0] = latch_q;
         end else if (paddr == `TRK_OFF_INT_STAT) begin
            prdata_d[`TRK_INT_W-1:0] = int_stat_q;
         end else if (paddr == `TRK_OFF_INT_MASK) begin
            prdata_d[`TRK_INT_W-1:0] = int_mask_q;
         end else if (paddr == `TRK_OFF_COUNT) begin
            prdata_d[15:0] = count_q & mask;
         end else begin
            pslverr_d = 1'b1;
         end
      end
      irq_d = |(int_stat_d & int_mask_d);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q     <= `TRK_CTRL_RESET;
         int_stat_q <= '0;
         int_mask_q <= '0;
         prdata     <= 32'h0000_0000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         irq        <= 1'b0;
      end else begin
         ctrl_q     <= ctrl_d;
         int_stat_q <= int_stat_d;
         int_mask_q <= int_mask_d;
         prdata     <= prdata_d;
         pready     <= pready_d;
         pslverr    <= pslverr_d;
         irq        <= irq_d;
      end
   end

   assign revolution_carry_pulse = carry_q;
   assign direction              = dir_q;
endmodule

// [testbench/rev_counter_model.sv]
// external revolution counter fed by the carry and direction pins
`timescale 1ns/10ps
module rev_counter_model (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // tracker pins
   input  wire logic        revolution_carry_pulse,
   input  wire logic        direction,
   // revolutions
   output logic      [15:0] revs_q
);
   logic        carry_q;
   logic [15:0] revs_d;
   always_comb begin
      revs_d = revs_q;
      if (revolution_carry_pulse && !carry_q) begin
         revs_d = direction ? revs_q + 16'h0001 : revs_q - 16'h0001;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         revs_q  <= 16'h0000;
         carry_q <= 1'b0;
      end else begin
         revs_q  <= revs_d;
         carry_q <= revolution_carry_pulse;
      end
   end
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the tracking position counter
`timescale 1ns/10ps
`include "tracker_defs.svh"
module tb_top;
   localparam logic [7:0] MAP = `TRK_RES_MAP;
   logic        pclk, presetn, psel, penable, pwrite, step_up, step_down;
   logic        pready, pslverr, busy, carry, direction, irq, data_pins_oe, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic [15:0] data_pins_out, revs, cnt, old;
   int          err_count, cmp_count, n;

   tracking_position_counter_outputs #(.RES_MAP(MAP)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .step_up(step_up), .step_down(step_down),
      .busy(busy), .revolution_carry_pulse(carry), .direction(direction), .irq(irq),
      .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe));
   rev_counter_model far_u (.pclk(pclk), .presetn(presetn), .revolution_carry_pulse(carry),
      .direction(direction), .revs_q(revs));

   always #10 pclk = ~pclk;

   task automatic close_out();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask

   // waits for pready, only the watchdog ends a hang
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r, x);
   endtask

   task automatic step(input logic [1:0] s, input int k);
      repeat (k) begin
         @(posedge pclk);
         step_up   <= s[0];
         step_down <= s[1];
         if (s == 2'b01) cnt = cnt + 16'h1;
         if (s == 2'b10) cnt = cnt - 16'h1;
      end
      @(posedge pclk);
      step_up   <= 1'b0;
      step_down <= 1'b0;
   endtask

   function automatic logic [31:0] mask(input int k);
      return (32'h1 << (10 + 2 * MAP[2*k+:2])) - 32'h1;
   endfunction

   initial begin
      #400000;
      err_count++;
      close_out();
   end

   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      step_up = 0; step_down = 0; cnt = 0; err_count = 0; cmp_count = 0;
      r = $urandom(32'hd757);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(`TRK_OFF_CTRL, 32'h08);
      rd(`TRK_OFF_STATUS, 32'h04);
      $display("-- reset done");
      apb(1'b1, `TRK_OFF_CTRL, 32'h03);
      apb(1'b1, `TRK_OFF_INT_MASK, 32'h02);
      step(2'b10, 1);
      repeat (4) @(posedge pclk);
      chk(carry, 1);
      chk(irq, 1);
      chk(revs, 16'hffff);
      apb(1'b1, `TRK_OFF_INT_STAT, 32'h0f);
      repeat (2) @(posedge pclk);
      chk(irq, 0);
      $display("-- wrap done");
      // mixed lengths give back-to-back steps, code 3 must be ignored
      repeat (200) step(2'($urandom % 4), 1 + $urandom % 3);
      repeat (12) @(posedge pclk);
      rd(`TRK_OFF_COUNT, cnt);
      rd(`TRK_OFF_POSITION, cnt);
      $display("-- random done");
      // an up step first, so the down steps under hold really flip direction
      step(2'b01, 1);
      repeat (12) @(posedge pclk);
      old = cnt;
      apb(1'b1, `TRK_OFF_CTRL, 32'h07);
      repeat (`TRK_VALID_CYC + 2) @(posedge pclk);
      rd(`TRK_OFF_POSITION, old);
      apb(1'b0, `TRK_OFF_STATUS, 32'h0);
      chk(r[`TRK_ST_LATCH_VALID], 1);
      step(2'b10, 3);
      repeat (12) @(posedge pclk);
      rd(`TRK_OFF_POSITION, old);
      rd(`TRK_OFF_COUNT, cnt);
      chk(direction, 0);
      apb(1'b1, `TRK_OFF_CTRL, 32'h03);
      n = 0;
      while (busy !== 1'b1 && n < 6) begin
         @(posedge pclk);
         n++;
      end
      chk(busy, 1);
      repeat (12) @(posedge pclk);
      rd(`TRK_OFF_POSITION, cnt);
      $display("-- hold done");
      chk(data_pins_oe, 1);
      chk(data_pins_out, {cnt[7:0], cnt[7:0]});
      apb(1'b1, `TRK_OFF_CTRL, 32'h13);
      repeat (3) @(posedge pclk);
      chk(data_pins_out, cnt);
      apb(1'b1, `TRK_OFF_CTRL, 32'h0b);
      repeat (3) @(posedge pclk);
      chk(data_pins_oe, 0);
      $display("-- pins done");
      for (int k = 0; k < 4; k++) begin
         // select changes only while busy is low
         while (busy !== 1'b0) @(posedge pclk);
         apb(1'b1, `TRK_OFF_CTRL, 32'(k));
         apb(1'b0, `TRK_OFF_STATUS, 32'h0);
         chk(r[5:4], MAP[2*k+:2]);
         // narrowing drops the upper count bits for good
         cnt = cnt & 16'(mask(k));
         rd(`TRK_OFF_COUNT, cnt);
      end
      apb(1'b1, `TRK_OFF_COUNT, 32'h1234);
      rd(`TRK_OFF_COUNT, cnt & mask(3));
      apb(1'b0, 8'h20, 32'h0);
      chk(e, 1);
      $display("-- registers done");
      close_out();
   end
endmodule

// [testbench/tracker_checker_props.sv]
// assertions on the tracker step, busy, carry and direction pins
`timescale 1ns/10ps
module tracker_checker (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // loop steps
   input wire logic step_up,
   input wire logic step_down,
   // status pins
   input wire logic busy,
   input wire logic revolution_carry_pulse,
   input wire logic direction
);
   logic stp;
   // both inputs high is no step
   assign stp = step_up ^ step_down;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_step_busy: assert property (stp |-> ##[1:3] busy)
      else $error("no busy pulse after a step");
   a_busy_width: assert property ($rose(busy) |-> busy [*8])
      else $error("busy pulse too short");
   a_carry_width: assert property ($rose(revolution_carry_pulse) |-> revolution_carry_pulse [*8])
      else $error("carry pulse too short");
   a_carry_cause: assert property ($rose(revolution_carry_pulse) |-> $past(stp) || $past(stp, 2))
      else $error("carry without a step");
   a_dir_before: assert property ($rose(revolution_carry_pulse) |-> $stable(direction))
      else $error("direction moved with carry");
   a_dir_up: assert property ((step_up && !step_down) |=> direction)
      else $error("direction not up");
   a_dir_down: assert property ((step_down && !step_up) |=> !direction)
      else $error("direction not down");
   a_dir_latch: assert property ($changed(direction) |-> $past(stp))
      else $error("direction moved without a step");
endmodule
bind tracking_position_counter_outputs tracker_checker chk_u (.pclk(pclk), .presetn(presetn),
   .step_up(step_up), .step_down(step_down), .busy(busy),
   .revolution_carry_pulse(revolution_carry_pulse), .direction(direction));
